//--- verilog/epiu_pkg.sv
// package: register map, field layout and encodings of the pin interrupt unit
package epiu_pkg;
    // register indices; the byte address on the bus is four times the index
    localparam logic [7:0] IDX_ENABLE = 8'h3D;
    localparam logic [7:0] IDX_SENSE = 8'h69;
    localparam logic [7:0] IDX_FLAGS = 8'h3E;
    localparam logic [7:0] IDX_GRP_EN = 8'h68;
    localparam logic [7:0] IDX_GRP_FLAG = 8'h3F;
    localparam logic [7:0] IDX_MASK0 = 8'h6B;
    localparam logic [7:0] IDX_MASK1 = 8'h6C;
    localparam logic [7:0] IDX_MASK2 = 8'h6D;
    localparam logic [7:0] IDX_STATUS = 8'h70;
    localparam logic [7:0] IDX_ACK = 8'h71;
    localparam int ADDR_W = 10;
    // sense field positions
    localparam int SENSE_PIN0_LSB = 0;
    localparam int SENSE_PIN1_LSB = 2;
    // reset values
    localparam logic [7:0] RST_REG = 8'h00;
    // sense modes
    typedef enum logic [1:0] {
        EPIU_LOW = 2'h0,
        EPIU_ANY = 2'h1,
        EPIU_FALL = 2'h2,
        EPIU_RISE = 2'h3
    } epiu_sense_e;
endpackage

//--- verilog/epiu_top.sv
// external pin interrupt unit: two sensed pins, 24 change inputs, APB slave
// Summary of operation
// - pins trigger regardless of their direction
// - group two: any enabled input 23..16 toggles
// - group one: any enabled input 14..8 toggles
// - group zero: any enabled input 7..0 toggles
// - change detection compares raw inputs, no synchroniser
// - low level requests while pin stays low
// - edge detection runs on the clock
// - low level request is purely combinational
// - level must last through start-up time
// - pin one sense field at bits 3:2
// - pin zero sense field at bits 1:0
// - pin sampled; pulses over one clock caught
// - pin request needs enable and global flag
// - unused register bits read as zero
// - pin edge sets its flag
// - pin flag clears on entry or write-one
// - flag reads cleared in low level mode
// - group request needs group enable and global
// - per input mask, reset zero
// - group flag set; cleared entry or write-one
module epiu_top
    import epiu_pkg::*;
#(
    parameter int NUM_CHANGE = 24
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // external pins
    input wire logic dedicated_pin_zero,
    input wire logic dedicated_pin_one,
    input wire logic [NUM_CHANGE-1:0] change_inputs,
    // cpu side
    input wire logic global_int_enable,
    input wire logic [4:0] vector_ack,
    output logic [4:0] int_request
);
    // group slices below are fixed, so refuse any other width
    if (NUM_CHANGE != 24) begin : g_bad_width
        $error("epiu_top: NUM_CHANGE must be 24");
    end

    logic [1:0] enable_reg;
    logic [3:0] sense_reg;
    logic [1:0] pin_flag;
    logic [2:0] grp_en;
    logic [2:0] grp_flag;
    logic [7:0] mask0;
    logic [6:0] mask1;
    logic [7:0] mask2;
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] prev;
    logic [2:0] warm;
    logic [NUM_CHANGE-1:0] chg_prev;

    // apb decode; single-cycle answer
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire [7:0] widx = paddr[ADDR_W-1:2];
    wire [7:0] wd = pwdata[7:0];
    wire hit_en = widx == IDX_ENABLE;
    wire hit_se = widx == IDX_SENSE;
    wire hit_fl = widx == IDX_FLAGS;
    wire hit_ge = widx == IDX_GRP_EN;
    wire hit_gf = widx == IDX_GRP_FLAG;
    wire hit_m0 = widx == IDX_MASK0;
    wire hit_m1 = widx == IDX_MASK1;
    wire hit_m2 = widx == IDX_MASK2;
    wire hit_st = widx == IDX_STATUS;
    wire hit_ak = widx == IDX_ACK;
    wire hit_any = hit_en | hit_se | hit_fl | hit_ge | hit_gf | hit_m0
        | hit_m1 | hit_m2 | hit_st | hit_ak;
    assign pready = 1'b1;
    assign pslverr = acc && !hit_any;

    // sense decode per pin
    function automatic logic edge_hit(input logic [1:0] m, input logic p,
                                      input logic c);
        case (m)
            EPIU_ANY: edge_hit = p ^ c;
            EPIU_FALL: edge_hit = p & ~c;
            EPIU_RISE: edge_hit = ~p & c;
            default: edge_hit = 1'b0;
        endcase
    endfunction

    wire [1:0] mode0 = sense_reg[SENSE_PIN0_LSB +: 2];
    wire [1:0] mode1 = sense_reg[SENSE_PIN1_LSB +: 2];
    // pins are read regardless of direction, no output gating here
    wire [1:0] pin_hit;
    // warm keeps the reset-zero sync chain from faking an edge on a high pin
    assign pin_hit[0] = edge_hit(mode0, prev[0], sync2[0])
        & warm[2];
    assign pin_hit[1] = edge_hit(mode1, prev[1], sync2[1])
        & warm[2];
    wire [1:0] is_low = {mode1 == EPIU_LOW, mode0 == EPIU_LOW};
    // low level path is combinational so it works with clock stopped
    // a level gone before start-up ends simply stops requesting
    wire [1:0] low_req = is_low & ~{dedicated_pin_one, dedicated_pin_zero};

    // change groups compare the raw input with its last value
    wire [NUM_CHANGE-1:0] toggled = change_inputs ^ chg_prev;
    wire [2:0] grp_hit;
    assign grp_hit[0] = |(toggled[7:0] & mask0);
    assign grp_hit[1] = |(toggled[14:8] & mask1);
    assign grp_hit[2] = |(toggled[23:16] & mask2);

    // requests: flag or low level, gated by enable and global flag
    wire [1:0] pin_src = (pin_flag & ~is_low) | low_req;
    assign int_request[1:0] = pin_src & enable_reg
        & {2{global_int_enable}};
    assign int_request[4:2] = grp_flag & grp_en
        & {3{global_int_enable}};

    // flag clears: write-one or vector entry
    wire [1:0] pin_clr = (wr && hit_fl ? wd[1:0] : 2'h0) | vector_ack[1:0];
    wire [2:0] grp_clr = (wr && hit_gf ? wd[2:0] : 3'h0) | vector_ack[4:2];
    // set wins over clear; level mode forces cleared
    wire [1:0] next_pin_flag = ((pin_flag & ~pin_clr) | pin_hit)
        & ~is_low;
    wire [2:0] next_grp_flag = (grp_flag & ~grp_clr) | grp_hit;

    // synchroniser for edge detection on the clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 2'h0;
            sync2 <= 2'h0;
            prev <= 2'h0;
            chg_prev <= '0;
        end else begin
            sync1 <= {dedicated_pin_one, dedicated_pin_zero};
            sync2 <= sync1;
            prev <= sync2;
            chg_prev <= change_inputs;
        end
    end

    // edge compare valid once prev holds a real pin sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            warm <= 3'h0;
        end else begin
            warm <= {warm[1:0], 1'b1};
        end
    end

    // flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_flag <= 2'h0;
            grp_flag <= 3'h0;
        end else begin
            pin_flag <= next_pin_flag;
            grp_flag <= next_grp_flag;
        end
    end

    // control registers, reset to zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_reg <= RST_REG[1:0];
            sense_reg <= RST_REG[3:0];
            grp_en <= RST_REG[2:0];
            mask0 <= RST_REG;
            mask1 <= RST_REG[6:0];
            mask2 <= RST_REG;
        end else if (wr) begin
            if (hit_en) enable_reg <= wd[1:0];
            if (hit_se) sense_reg <= wd[3:0];
            if (hit_ge) grp_en <= wd[2:0];
            if (hit_m0) mask0 <= wd;
            if (hit_m1) mask1 <= wd[6:0];
            if (hit_m2) mask2 <= wd;
        end
    end

    // read mux; unused bits zero
    wire [7:0] rd =
        hit_en ? {6'h00, enable_reg} :
        hit_se ? {4'h0, sense_reg} :
        hit_fl ? {6'h00, pin_flag} :
        hit_ge ? {5'h00, grp_en} :
        hit_gf ? {5'h00, grp_flag} :
        hit_m0 ? mask0 :
        hit_m1 ? {1'b0, mask1} :
        hit_m2 ? mask2 :
        hit_st ? {3'h0, int_request} : 8'h00;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h000000, rd};
        end
    end

    // ---- assertions
    property p_edge_flag;
        @(posedge pclk) disable iff (!presetn)
        pin_hit[0] |=> pin_flag[0];
    endproperty
    a_edge_flag: assert property (p_edge_flag) else $error("flag0 not set");

    property p_level_clear;
        @(posedge pclk) disable iff (!presetn)
        is_low[1] |=> !pin_flag[1] || !is_low[1];
    endproperty
    a_level_clear: assert property (p_level_clear)
        else $error("flag1 set in level mode");

    property p_low_req;
        @(posedge pclk) disable iff (!presetn)
        (is_low[0] && !dedicated_pin_zero && enable_reg[0]
            && global_int_enable) |-> int_request[0];
    endproperty
    a_low_req: assert property (p_low_req) else $error("no level request");

    property p_gate;
        @(posedge pclk) disable iff (!presetn)
        !global_int_enable |-> int_request == 5'h00;
    endproperty
    a_gate: assert property (p_gate) else $error("request without global");

    sequence s_rise0;
        mode0 == EPIU_RISE && !sync2[0] ##1 sync2[0] && mode0 == EPIU_RISE;
    endsequence
    property p_rise;
        @(posedge pclk) disable iff (!presetn)
        s_rise0 |=> pin_flag[0];
    endproperty
    a_rise: assert property (p_rise) else $error("rise missed");

    property p_grp2;
        @(posedge pclk) disable iff (!presetn)
        |((change_inputs[23:16] ^ $past(change_inputs[23:16])) & mask2)
            |=> grp_flag[2];
    endproperty
    a_grp2: assert property (p_grp2) else $error("group2 missed");

    property p_grp_clr;
        @(posedge pclk) disable iff (!presetn)
        vector_ack[2] && !grp_hit[0] |=> !grp_flag[0];
    endproperty
    a_grp_clr: assert property (p_grp_clr) else $error("group0 not cleared");

    property p_mask;
        @(posedge pclk) disable iff (!presetn)
        mask1 == 7'h00 && !grp_flag[1] |=> !grp_flag[1];
    endproperty
    a_mask: assert property (p_mask) else $error("masked group set");

    sequence s_fall1;
        warm[2] && mode1 == EPIU_FALL && sync2[1]
        ##1 !sync2[1] && mode1 == EPIU_FALL;
    endsequence
    property p_fall1;
        @(posedge pclk) disable iff (!presetn)
        s_fall1 |=> pin_flag[1];
    endproperty
    a_fall1: assert property (p_fall1)
        else $error("fall on pin one missed");

    property p_any0;
        @(posedge pclk) disable iff (!presetn)
        (warm[2] && mode0 == EPIU_ANY && sync2[0] != prev[0]) |=> pin_flag[0];
    endproperty
    a_any0: assert property (p_any0)
        else $error("toggle on pin zero missed");

    property p_wr_clr;
        @(posedge pclk) disable iff (!presetn)
        (wr && hit_fl && wd[0] && !pin_hit[0]) |=> !pin_flag[0];
    endproperty
    a_wr_clr: assert property (p_wr_clr)
        else $error("write one left flag0 set");

    property p_ack_clr;
        @(posedge pclk) disable iff (!presetn)
        (vector_ack[1] && !pin_hit[1]) |=> !pin_flag[1];
    endproperty
    a_ack_clr: assert property (p_ack_clr)
        else $error("entry left flag1 set");

    property p_grp0;
        @(posedge pclk) disable iff (!presetn)
        |((change_inputs[7:0] ^ $past(change_inputs[7:0])) & mask0)
            |=> grp_flag[0];
    endproperty
    a_grp0: assert property (p_grp0) else $error("group0 missed");

    property p_grp1;
        @(posedge pclk) disable iff (!presetn)
        |((change_inputs[14:8] ^ $past(change_inputs[14:8])) & mask1)
            |=> grp_flag[1];
    endproperty
    a_grp1: assert property (p_grp1) else $error("group1 missed");

    property p_grp_gate;
        @(posedge pclk) disable iff (!presetn)
        !grp_en[2] |-> !int_request[4];
    endproperty
    a_grp_gate: assert property (p_grp_gate)
        else $error("group2 request while disabled");

    property p_pin_gate;
        @(posedge pclk) disable iff (!presetn)
        !enable_reg[1] |-> !int_request[1];
    endproperty
    a_pin_gate: assert property (p_pin_gate)
        else $error("pin1 request while disabled");

    property p_rd_zero;
        @(posedge pclk) disable iff (!presetn)
        (psel && penable && !pwrite) |-> prdata[31:8] == 24'h000000;
    endproperty
    a_rd_zero: assert property (p_rd_zero)
        else $error("upper read bits not zero");

    property p_low1;
        @(posedge pclk) disable iff (!presetn)
        (is_low[1] && !dedicated_pin_one && enable_reg[1]
            && global_int_enable) |-> int_request[1];
    endproperty
    a_low1: assert property (p_low1)
        else $error("no level request on pin one");

    property p_sync;
        @(posedge pclk) disable iff (!presetn)
        warm[2] |-> sync2 == $past({dedicated_pin_one, dedicated_pin_zero}, 2);
    endproperty
    a_sync: assert property (p_sync)
        else $error("sync chain length wrong");

    property p_set_wins;
        @(posedge pclk) disable iff (!presetn)
        (vector_ack[4] && grp_hit[2]) |=> grp_flag[2];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("clear beat a new group2 change");
endmodule // epiu_top

//--- tb/epiu_cpu_model.sv
// cpu dispatch model: enters the vector of the lowest pending request
module epiu_cpu_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // dispatch side
    input wire logic ack_en,
    input wire logic [4:0] int_request,
    output logic [4:0] vector_ack
);
    timeunit 1ns;
    timeprecision 1ns;
    // one-hot entry pulse; the gap cycle lets the flag drop first
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vector_ack <= 5'h00;
        end else if (ack_en && vector_ack == 5'h00) begin
            vector_ack <= int_request & (~int_request + 5'h01);
        end else begin
            vector_ack <= 5'h00;
        end
    end
endmodule // epiu_cpu_model

//--- tb/external_pin_interrupt_unit_tb_top.sv
// testbench: registers, pin sense modes, levels, change groups
module external_pin_interrupt_unit_tb_top import epiu_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, lfsr;
    logic pin0, pin1, gie, ack_en;
    logic [23:0] chg;
    logic [4:0] req, ack;
    logic [32:0] exp_q[$];
    int fails, n_compared, b, on, off;
    logic [7:0] ridx[10] = '{IDX_ENABLE, IDX_SENSE, IDX_FLAGS, IDX_GRP_EN,
        IDX_GRP_FLAG, IDX_MASK0, IDX_MASK1, IDX_MASK2, IDX_STATUS, IDX_ACK};
    logic [7:0] rmsk[10] = '{8'h03, 8'h0F, 8'h00, 8'h07, 8'h00, 8'hFF,
        8'h7F, 8'hFF, 8'h00, 8'h00};
    epiu_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .dedicated_pin_zero(pin0),
        .dedicated_pin_one(pin1), .change_inputs(chg),
        .global_int_enable(gie), .vector_ack(ack), .int_request(req));
    epiu_cpu_model cpu (.pclk(pclk), .presetn(presetn), .ack_en(ack_en),
        .int_request(req), .vector_ack(ack));
    // 100 MHz clock
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic cmp_read(input logic [32:0] got, input logic [32:0] ex);
        n_compared++;
        if (got !== ex) begin
            fails++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, ex);
        end
    endtask
    // apb master; upper write bits are random, the slave ignores them
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd, input logic [8:0] ex);
        int n;
        @(posedge pclk);
        lfsr = next_rand(lfsr);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'h0};
        pwdata <= {lfsr[31:8], wd};
        if (!wr) exp_q.push_back({ex[8], 24'h000000, ex[7:0]});
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fails++;
            give_verdict();
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d, 9'h000);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [8:0] ex);
        apb(1'b0, idx, 8'h00, ex);
    endtask
    task automatic idle(input int c);
        repeat (c) @(posedge pclk);
    endtask
    task automatic set_pin(input int p, input logic v);
        @(posedge pclk);
        if (p == 1) pin1 <= v;
        else pin0 <= v;
    endtask
    // oldest note against each completed read, error flag included
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            cmp_read({pslverr, prdata}, exp_q.size() ? exp_q.pop_front() : '1);
        end
    end
    // hang guard
    initial begin
        #500000;
        fails++;
        give_verdict();
    end
    initial begin
        {psel, penable, pwrite, gie, ack_en, presetn} = 6'h00;
        {paddr, pwdata, chg} = '0;
        {pin0, pin1} = 2'h3;
        lfsr = 32'h35e3;
        fails = 0;
        n_compared = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, then all ones shows only the writable bits
        foreach (ridx[i]) begin
            rd(ridx[i], 9'h000);
            wr(ridx[i], 8'hFF);
            rd(ridx[i], {1'b0, rmsk[i]});
            wr(ridx[i], 8'h00);
        end
        rd(8'h00, 9'h100);
        // every sense mode on both pins: falling then rising edge
        for (int p = 0; p < 2; p++) begin
            for (int m = 0; m < 4; m++) begin
                wr(IDX_SENSE, 8'(m << (2 * p)));
                wr(IDX_FLAGS, 8'h03);
                set_pin(p, 1'b0);
                idle(4);
                rd(IDX_FLAGS, {8'h00, m == 1 || m == 2} << p);
                wr(IDX_FLAGS, 8'h03);
                set_pin(p, 1'b1);
                idle(4);
                rd(IDX_FLAGS, {8'h00, m == 1 || m == 3} << p);
            end
        end
        // low level: held past the read, released only after it
        wr(IDX_SENSE, 8'h00);
        wr(IDX_ENABLE, 8'h01);
        gie <= 1'b1;
        set_pin(0, 1'b0);
        rd(IDX_STATUS, 9'h001);
        gie <= 1'b0;
        rd(IDX_STATUS, 9'h000);
        set_pin(0, 1'b1);
        // pin one edge request, then vector entry clears its flag
        wr(IDX_SENSE, 8'h08);
        wr(IDX_ENABLE, 8'h02);
        gie <= 1'b1;
        set_pin(1, 1'b0);
        idle(4);
        rd(IDX_STATUS, 9'h002);
        ack_en <= 1'b1;
        idle(4);
        rd(IDX_FLAGS, 9'h000);
        ack_en <= 1'b0;
        // one random masked-in input per group, neighbour masked out
        wr(IDX_GRP_EN, 8'h07);
        for (int g = 0; g < 3; g++) begin
            b = int'(lfsr[2:0]) % 7;
            on = 8 * g + b;
            off = 8 * g + (b + 1) % 7;
            wr(IDX_MASK0 + 8'(g), 8'h01 << b);
            chg <= chg ^ (24'h000001 << off);
            idle(2);
            rd(IDX_GRP_FLAG, 9'h000);
            chg <= chg ^ (24'h000001 << on);
            idle(2);
            rd(IDX_STATUS, 9'h004 << g);
            wr(IDX_GRP_FLAG, 8'h07);
            rd(IDX_GRP_FLAG, 9'h000);
        end
        // input 15 belongs to no group
        wr(IDX_MASK1, 8'hFF);
        chg <= chg ^ 24'h008000;
        idle(2);
        rd(IDX_GRP_FLAG, 9'h000);
        give_verdict();
    end
endmodule // external_pin_interrupt_unit_tb_top
